// ### src/pcc_pkg.sv
// Shared constants, register layout and carrier types for the PLL clock configuration block.
package pcc_pkg;

	localparam int PCC_AW = 12;
	localparam int PCC_DW = 32;
	localparam int PCC_DVF_W = 5;
	localparam int PCC_MLT_W = 6;

	localparam logic [PCC_AW-1:0] PCC_CTRL_OFFSET = 12'h000;
	localparam logic [PCC_AW-1:0] PCC_STAT_OFFSET = 12'h004;

	localparam int PCC_DVF_LSB = 0;
	localparam int PCC_MLT_LSB = 8;
	localparam int PCC_RNG_BIT = 16;
	localparam int PCC_SEL_LSB = 17;

	localparam int PCC_STAT_LOCK_BIT = 0;
	localparam int PCC_STAT_SRC_LSB = 1;
	localparam int PCC_STAT_RSVD_BIT = 4;
	localparam int PCC_STAT_DVF_BAD_BIT = 5;
	localparam int PCC_STAT_FACTOR_LSB = 8;

	localparam logic [PCC_DVF_W-1:0] PCC_DVF_RST = 5'h00;
	localparam logic [PCC_MLT_W-1:0] PCC_MLT_RST = 6'h00;
	localparam logic PCC_RNG_RST = 1'b0;
	localparam logic [1:0] PCC_SEL_RST = 2'h0;
	localparam logic [PCC_DVF_W-1:0] PCC_DVF_MAX = 5'h09;

	localparam logic [1:0] PCC_SEL_REF = 2'h0;
	localparam logic [1:0] PCC_SEL_VCO_DIV2 = 2'h1;
	localparam logic [1:0] PCC_SEL_VCO = 2'h3;

	localparam logic [2:0] PCC_FACTOR_NONE = 3'h0;
	localparam logic [2:0] PCC_FACTOR_2 = 3'h2;
	localparam logic [2:0] PCC_FACTOR_4 = 3'h4;

	localparam int PCC_SYNC_STAGES = 2;

	typedef struct packed {
		logic [1:0] sel;
		logic vco_range_bit;
		logic [PCC_MLT_W-1:0] mlt;
		logic [PCC_DVF_W-1:0] dvf;
	} pcc_ctrl_t;

	typedef enum logic [2:0] {
		PCC_SRC_REF = 3'b001,
		PCC_SRC_WAIT = 3'b010,
		PCC_SRC_PLL = 3'b100
	} pcc_src_state_t;

	typedef struct packed {
		logic [PCC_DVF_W:0] in_div;
		logic [PCC_MLT_W:0] loop_mult;
		logic vco_range;
		logic core_ref;
		logic core_vco;
		logic core_vco_div2;
		logic [2:0] div_factor;
	} pcc_clk_cfg_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [PCC_AW-1:0] paddr;
		logic [PCC_DW-1:0] pwdata;
	} pcc_apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [PCC_DW-1:0] prdata;
	} pcc_apb_rsp_t;

	typedef struct packed {
		pcc_ctrl_t ctrl;
		pcc_src_state_t src;
		logic [1:0] act_sel;
		logic rsvd_seen;
		pcc_clk_cfg_t out;
		logic [PCC_DW-1:0] rdata;
		logic slverr;
	} pcc_state_t;

endpackage

// ### src/pcc_sync.sv
// Two-stage level synchroniser for the asynchronous PLL lock indication.
`timescale 1ns/10ps
module pcc_sync
	import pcc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic async_in,
	output logic sync_out
);

	logic [PCC_SYNC_STAGES-1:0] stage_q;

	// Only the last stage is visible; the first may be metastable.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage_q <= '0;
		end else begin
			stage_q <= {stage_q[PCC_SYNC_STAGES-2:0], async_in};
		end
	end

	assign sync_out = stage_q[PCC_SYNC_STAGES-1];

endmodule

// ### src/pcc_top.sv
// APB-programmed clock configuration and core clock source control around an on-chip PLL.
`timescale 1ns/10ps
// Function
// - Input divider ratio is the divide field plus one, feeding the multiplier.
// - Loop multiplier ratio is the multiply field plus one, giving loop frequency.
// - Range bit one uses loop frequency as VCO; zero uses half of it.
// - Core clock comes from reference input, VCO, or VCO divided by two.
// - Select and range give division 2, 2, 4; select 11 with range 1 reserved.
module pcc_top
	import pcc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input pcc_apb_req_t apb_req,
	output pcc_apb_rsp_t apb_rsp,
	input wire logic pll_lock,
	output pcc_clk_cfg_t clk_cfg
);

	pcc_state_t q;
	pcc_state_t d;
	logic lock_s;

	pcc_sync u_lock_sync (
		.clk(pclk),
		.rst_n(presetn),
		.async_in(pll_lock),
		.sync_out(lock_s)
	);

	// Both PLL-derived codes pick a VCO path; the other two codes pick the reference.
	function automatic logic is_pll_src(input logic [1:0] sel);
		return (sel == PCC_SEL_VCO) || (sel == PCC_SEL_VCO_DIV2);
	endfunction

	function automatic logic is_reserved(input pcc_ctrl_t c);
		return (c.sel == PCC_SEL_VCO) && c.vco_range_bit;
	endfunction

	function automatic logic [2:0] div_factor(input pcc_ctrl_t c);
		logic [2:0] f;
		f = PCC_FACTOR_NONE;
		if (c.sel == PCC_SEL_VCO && !c.vco_range_bit) begin
			f = PCC_FACTOR_2;
		end else if (c.sel == PCC_SEL_VCO_DIV2 && c.vco_range_bit) begin
			f = PCC_FACTOR_2;
		end else if (c.sel == PCC_SEL_VCO_DIV2 && !c.vco_range_bit) begin
			f = PCC_FACTOR_4;
		end
		return f;
	endfunction

	logic wr_access;
	logic setup_phase;
	logic req_pll;
	logic cfg_change;
	logic [PCC_DW-1:0] ctrl_word;
	logic [PCC_DW-1:0] stat_word;

	always_comb begin
		d = q;
		wr_access = apb_req.psel && apb_req.penable && apb_req.pwrite;
		setup_phase = apb_req.psel && !apb_req.penable;

		if (wr_access && apb_req.paddr == PCC_CTRL_OFFSET) begin
			d.ctrl.dvf = apb_req.pwdata[PCC_DVF_LSB +: PCC_DVF_W];
			d.ctrl.mlt = apb_req.pwdata[PCC_MLT_LSB +: PCC_MLT_W];
			d.ctrl.vco_range_bit = apb_req.pwdata[PCC_RNG_BIT];
			d.ctrl.sel = apb_req.pwdata[PCC_SEL_LSB +: 2];
		end

		// A reserved pairing still held in the control register beats a clear of the flag.
		if (wr_access && apb_req.paddr == PCC_STAT_OFFSET &&
				apb_req.pwdata[PCC_STAT_RSVD_BIT]) begin
			d.rsvd_seen = 1'b0;
		end
		if (is_reserved(d.ctrl)) begin
			d.rsvd_seen = 1'b1;
		end

		req_pll = is_pll_src(d.ctrl.sel) && !is_reserved(d.ctrl);
		cfg_change = (d.ctrl.dvf != q.ctrl.dvf) || (d.ctrl.mlt != q.ctrl.mlt) ||
			(d.ctrl.vco_range_bit != q.ctrl.vco_range_bit);

		// Retuning the PLL unlocks it, so the core falls back to the reference
		// and waits for lock again rather than run on a drifting VCO.
		unique case (q.src)
			PCC_SRC_REF: begin
				if (req_pll) begin
					d.src = PCC_SRC_WAIT;
				end
			end
			PCC_SRC_WAIT: begin
				if (!req_pll || cfg_change) begin
					d.src = PCC_SRC_REF;
				end else if (lock_s) begin
					d.src = PCC_SRC_PLL;
				end
			end
			PCC_SRC_PLL: begin
				if (!req_pll || cfg_change || !lock_s) begin
					d.src = PCC_SRC_REF;
				end
			end
		endcase

		if (d.src == PCC_SRC_PLL) begin
			d.act_sel = d.ctrl.sel;
		end else begin
			d.act_sel = PCC_SEL_REF;
		end

		d.out.in_div = {1'b0, d.ctrl.dvf} + 6'h01;
		d.out.loop_mult = {1'b0, d.ctrl.mlt} + 7'h01;
		d.out.vco_range = d.ctrl.vco_range_bit;
		d.out.core_ref = (d.src != PCC_SRC_PLL);
		d.out.core_vco = (d.src == PCC_SRC_PLL) && (d.act_sel == PCC_SEL_VCO);
		d.out.core_vco_div2 = (d.src == PCC_SRC_PLL) &&
			(d.act_sel == PCC_SEL_VCO_DIV2);
		d.out.div_factor = div_factor(d.ctrl);

		ctrl_word = '0;
		ctrl_word[PCC_DVF_LSB +: PCC_DVF_W] = q.ctrl.dvf;
		ctrl_word[PCC_MLT_LSB +: PCC_MLT_W] = q.ctrl.mlt;
		ctrl_word[PCC_RNG_BIT] = q.ctrl.vco_range_bit;
		ctrl_word[PCC_SEL_LSB +: 2] = q.ctrl.sel;

		stat_word = '0;
		stat_word[PCC_STAT_LOCK_BIT] = lock_s;
		stat_word[PCC_STAT_SRC_LSB +: 3] = {q.out.core_vco_div2, q.out.core_vco,
			q.out.core_ref};
		stat_word[PCC_STAT_RSVD_BIT] = q.rsvd_seen;
		stat_word[PCC_STAT_DVF_BAD_BIT] = (q.ctrl.dvf > PCC_DVF_MAX);
		stat_word[PCC_STAT_FACTOR_LSB +: 3] = q.out.div_factor;

		// Read data and error are prepared in the setup cycle so that the
		// access phase can complete at once from flip-flops.
		if (setup_phase) begin
			d.slverr = 1'b0;
			unique case (apb_req.paddr)
				PCC_CTRL_OFFSET: begin
					d.rdata = ctrl_word;
				end
				PCC_STAT_OFFSET: begin
					d.rdata = stat_word;
				end
				default: begin
					d.rdata = '0;
					d.slverr = 1'b1;
				end
			endcase
			if (apb_req.pwrite) begin
				d.rdata = '0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q.ctrl.dvf <= PCC_DVF_RST;
			q.ctrl.mlt <= PCC_MLT_RST;
			q.ctrl.vco_range_bit <= PCC_RNG_RST;
			q.ctrl.sel <= PCC_SEL_RST;
			q.src <= PCC_SRC_REF;
			q.act_sel <= PCC_SEL_REF;
			q.rsvd_seen <= 1'b0;
			q.out.in_div <= 6'h01;
			q.out.loop_mult <= 7'h01;
			q.out.vco_range <= PCC_RNG_RST;
			q.out.core_ref <= 1'b1;
			q.out.core_vco <= 1'b0;
			q.out.core_vco_div2 <= 1'b0;
			q.out.div_factor <= PCC_FACTOR_NONE;
			q.rdata <= '0;
			q.slverr <= 1'b0;
		end else begin
			q <= d;
		end
	end

	assign apb_rsp.pready = 1'b1;
	assign apb_rsp.pslverr = q.slverr;
	assign apb_rsp.prdata = q.rdata;
	assign clk_cfg = q.out;

endmodule

// ### verif/pcc_top_chk.sv
// Concurrent checks on the clock configuration block's ports.
`timescale 1ns/10ps
module pcc_top_chk
	import pcc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input pcc_apb_req_t apb_req,
	input pcc_apb_rsp_t apb_rsp,
	input wire logic pll_lock,
	input pcc_clk_cfg_t clk_cfg
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic wr;
	logic [31:0] d;
	assign d = apb_req.pwdata;
	assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite &
		(apb_req.paddr == PCC_CTRL_OFFSET);
	chk_in_div_ratio: assert property (wr |=>
		clk_cfg.in_div == {1'b0, $past(d[4:0])} + 6'h01) else $error("input ratio wrong");
	chk_loop_mult_ratio: assert property (wr |=>
		clk_cfg.loop_mult == {1'b0, $past(d[13:8])} + 7'h01) else $error("loop ratio wrong");
	chk_range_follows: assert property (wr |=>
		clk_cfg.vco_range == $past(d[16])) else $error("range bit wrong");
	chk_core_onehot: assert property (
		$onehot({clk_cfg.core_ref, clk_cfg.core_vco, clk_cfg.core_vco_div2})) else $error("core mux");
	chk_factor_four: assert property (wr && d[18:16] == 3'b010 |=>
		clk_cfg.div_factor == 3'h4) else $error("factor four wrong");
	chk_factor_two: assert property (wr && (d[18:16] == 3'b011 || d[18:16] == 3'b110) |=>
		clk_cfg.div_factor == 3'h2) else $error("factor two wrong");
	// A reserved pairing must never reach the PLL path, so it is held on the reference.
	chk_ref_fallback: assert property (wr && (!d[17] || d[18:16] == 3'b111) |=>
		clk_cfg.core_ref [*2]) else $error("reference not kept");
	// The source waits one cycle for lock before the VCO path is taken.
	cover property (wr ##2 clk_cfg.core_vco [*2]);
	cover property (clk_cfg.core_vco_div2);
	cover property (apb_rsp.pslverr);
endmodule
bind pcc_top pcc_top_chk u_pcc_top_chk(.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
	.apb_rsp(apb_rsp), .pll_lock(pll_lock), .clk_cfg(clk_cfg));

// ### verif/tb_top.sv
// Self-checking bench for the clock configuration block.
`timescale 1ns/10ps
module tb_top
	import pcc_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic pll_lock = 1'b0;
	pcc_apb_req_t req = '0;
	pcc_apb_rsp_t rsp;
	pcc_clk_cfg_t cfg;
	int fail_count = 0;
	int compares = 0;
	int cyc = 0;
	logic [31:0] r;
	logic e;
	pcc_top u_pcc_top(.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
		.pll_lock(pll_lock), .clk_cfg(cfg));
	initial begin
		forever #5 pclk = ~pclk;
	end
	task automatic test_done();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			test_done();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			fail_count++;
		end
	endtask
	// The request is held until pready is seen high; a spare cycle follows the release.
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= w;
		req.paddr <= a;
		req.pwdata <= wd;
		@(posedge pclk);
		req.penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (rsp.pready !== 1'b1);
		r = rsp.prdata;
		e = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		@(posedge pclk);
	endtask
	initial begin
		logic [1:0] s;
		logic g;
		logic [2:0] ef;
		logic [2:0] ec;
		int n;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(cfg.in_div, 1);
		chk(cfg.loop_mult, 1);
		chk({cfg.core_ref, cfg.core_vco, cfg.core_vco_div2}, 3'b100);
		pll_lock <= 1'b1;
		xfer(1'b0, 12'h008, 32'h0);
		chk(r, 32'h0);
		chk(e, 1'b1);
		for (int i = 0; i < 8; i++) begin
			s = i[2:1];
			g = i[0];
			ef = (s == 2'h1) ? (g ? 3'h2 : 3'h4) : ((s == 2'h3 && !g) ? 3'h2 : 3'h0);
			ec = (s == 2'h1) ? 3'b001 : ((s == 2'h3 && !g) ? 3'b010 : 3'b100);
			// A 100 MHz reference divided by 4 and multiplied by 16 keeps every limit.
			xfer(1'b1, PCC_CTRL_OFFSET, 32'h0000_0F03);
			xfer(1'b1, PCC_CTRL_OFFSET, {13'h0, s, g, 16'h0F03});
			chk(cfg.in_div, 4);
			chk(cfg.loop_mult, 7'h10);
			chk(cfg.vco_range, g);
			chk(cfg.div_factor, ef);
			n = 0;
			while ({cfg.core_ref, cfg.core_vco, cfg.core_vco_div2} !== ec && n < 8) begin
				@(posedge pclk);
				n++;
			end
			chk({cfg.core_ref, cfg.core_vco, cfg.core_vco_div2}, ec);
			xfer(1'b0, PCC_STAT_OFFSET, 32'h0);
			chk(r[10:8], ef);
		end
		xfer(1'b0, PCC_STAT_OFFSET, 32'h0);
		chk(r[4:0], 5'h13);
		xfer(1'b1, PCC_STAT_OFFSET, 32'h0000_0010);
		xfer(1'b0, PCC_STAT_OFFSET, 32'h0);
		chk(r[4], 1'b1);
		xfer(1'b1, PCC_CTRL_OFFSET, 32'h0000_0F03);
		xfer(1'b1, PCC_STAT_OFFSET, 32'h0000_0010);
		xfer(1'b0, PCC_STAT_OFFSET, 32'h0);
		chk(r[4], 1'b0);
		test_done();
	end
endmodule
